// ### design/mli_pkg.sv
package mli_pkg;
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h01;
	localparam logic [7:0] OFS_MASK = 8'h03;
	localparam logic [7:0] OFS_RATE = 8'h07;
	localparam logic [7:0] OFS_DIS = 8'h08;
	localparam logic [7:0] OFS_ONESHOT = 8'h09;
	localparam logic [7:0] OFS_DEEP = 8'h0A;
	localparam logic [7:0] OFS_ADV = 8'h0B;
	localparam logic [7:0] OFS_BUSY = 8'h0C;
	localparam logic [7:0] OFS_READ0 = 8'h20;
	localparam logic [7:0] OFS_READ7 = 8'h27;
	localparam logic [7:0] OFS_LIM0 = 8'h2A;
	localparam logic [7:0] OFS_THOT = 8'h38;
	localparam logic [7:0] OFS_THYST = 8'h39;

	localparam logic [7:0] RST_CFG = 8'h08;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] RST_DIS = 8'h00;
	localparam logic [7:0] RST_DEEP = 8'h00;
	localparam logic [7:0] RST_ADV = 8'h00;
	localparam logic [7:0] RST_BUSY = 8'h02;
	localparam logic [7:0] RST_LIM = 8'h00;
	localparam logic [15:0] RST_READ = 16'h0000;

	localparam int CFG_START = 0;
	localparam int CFG_INT_EN = 1;
	localparam int CFG_INT_CLR = 3;
	localparam int CFG_INIT = 7;
	localparam int ADV_REF = 0;
	localparam int ADV_MODE_LO = 1;
	localparam int RATE_CONT = 0;
	localparam int DEEP_EN = 0;
	localparam int BUSY_BUSY = 0;
	localparam int BUSY_NRDY = 1;
	localparam logic [2:0] TEMP_CH = 3'h7;

	localparam int CLK_MHZ = 100;
	localparam int LP_PASS_MS = 728;
	localparam int READY_MS = 33;
	localparam int LP_PASS_CYC = LP_PASS_MS * 1000 * CLK_MHZ;
	localparam int READY_CYC = READY_MS * 1000 * CLK_MHZ;

	typedef enum {S_OFF, S_PICK, S_CONV, S_WAIT} mli_seq_t;
	typedef enum {I_IDLE, I_RX, I_RX_ACK, I_TX, I_TX_ACK} mli_i2c_t;

	function automatic logic chan_used(input logic [1:0] mode, input logic [2:0] ch);
		case (mode)
			2'h2: chan_used = (ch < 3'h4) || (ch == TEMP_CH);
			2'h3: chan_used = (ch < 3'h6) || (ch == TEMP_CH);
			default: chan_used = 1'b1;
		endcase
	endfunction : chan_used

	function automatic logic chan_temp(input logic [1:0] mode, input logic [2:0] ch);
		chan_temp = (ch == TEMP_CH) && (mode != 2'h1);
	endfunction : chan_temp
endpackage : mli_pkg

// ### design/mli_cmp_if.sv
`timescale 1ns/1ps
interface mli_cmp_if;
	logic [15:0] reading;
	logic [7:0] hi_lim;
	logic [7:0] lo_lim;
	logic is_temp;
	logic out_lim;
	logic at_hyst;
	modport src (output reading, output hi_lim, output lo_lim, output is_temp,
		input out_lim, input at_hyst);
	modport cmp (input reading, input hi_lim, input lo_lim, input is_temp,
		output out_lim, output at_hyst);
endinterface : mli_cmp_if

// ### design/mli_limit_cmp.sv
`timescale 1ns/1ps
module mli_limit_cmp (
	mli_cmp_if.cmp cif
);
	logic signed [9:0] t_half;
	logic signed [9:0] hot_half;
	logic signed [9:0] hyst_half;

	// Limits are whole degrees, readings half degrees: scale limits by two
	always_comb begin
		t_half = signed'({cif.reading[8], cif.reading[8:0]});
		hot_half = signed'({cif.hi_lim[7], cif.hi_lim, 1'b0});
		hyst_half = signed'({cif.lo_lim[7], cif.lo_lim, 1'b0});
		if (cif.is_temp) begin
			cif.out_lim = t_half > hot_half;
			cif.at_hyst = t_half <= hyst_half;
		end else begin
			// Voltage limits weigh the top eight bits of the 12-bit code
			cif.out_lim = (cif.reading[11:4] > cif.hi_lim) ||
				(cif.reading[11:4] <= cif.lo_lim);
			cif.at_hyst = 1'b0;
		end
	end
endmodule : mli_limit_cmp

// ### design/mli_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Temperature code: 9-bit two's complement, half degree
// - Temperature limits: 8-bit two's complement, whole degree
// - High limit 38h, hysteresis 39h; above high flags
// - Alert low needs clear=0, enable=1, unmasked event
// - Voltage out: above high or at/below low
// - Status read returns then clears; alert releases
// - Clear bit releases alert, halts loop while set
// - Temperature interrupt holds until read or clear
// - Re-raise each temperature conversion until hysteresis plus read
// - Low power: one pass, then shutdown, 728 ms
// - Channel set per mode 0 to 3
// - Any write to 09h starts one pass unless clear bit set
// - Busy register: busy and not-ready, resets 02h
// - Readings read-only 16-bit at 20h to 27h
// - Mask blocks alert only, status unaffected
// - Disabled channels skipped by loop
// - Advanced register picks reference and mode
// - 0Ah deep shutdown enable, 07h conversion rate
// - Status register one bit per channel, resets zero
// - Control resets 08h: clear set, loop stopped
// - Advanced bit 0 reference, bits 2:1 mode
// - Start bit runs loop; low means shutdown, bus alive
module mli_top #(
	parameter logic [6:0] DEV_ADDR = 7'h1D, // Arbitrary bus address
	parameter int LP_PASS_CYCLES = mli_pkg::LP_PASS_CYC,
	parameter int READY_CYCLES = mli_pkg::READY_CYC
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic int_n,
	output logic conv_start,
	output logic [2:0] conv_chan,
	output logic conv_temp,
	output logic conv_ref_ext,
	output logic deep_sleep,
	output logic shutdown,
	input wire logic conv_done,
	input wire logic [15:0] conv_data
);
	import mli_pkg::*;

	logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
	mli_i2c_t i_st;
	logic [1:0] byte_no_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] sh_r, tx_r, ptr_r, rd_val, wr_dat_r;
	logic rw_r, hi_sel_r, sda_oe_r, wr_stb_r, rd_load_r;
	logic [7:0] cfg_r, status_r, mask_r, rate_r, dis_r, deep_r, adv_r, set_vec;
	logic [7:0] lim_r [16];
	logic [15:0] rd_r [8];
	mli_seq_t seq_st, pass_end_st;
	logic [2:0] ch_r, conv_chan_r;
	logic [31:0] tmr_r, rdy_cnt_r;
	logic conv_start_r, conv_temp_r, shut_r, int_n_r, nrdy_r, os_pend_r, os_act_r;
	logic temp_hot_r, hyst_rd_r;
	logic [1:0] mode;
	logic scl_rise, scl_fall, bus_start, bus_stop, soft_init, st_rd, os_wr;
	logic run_ok, cur_temp, conv_fin, temp_done, busy;

	mli_cmp_if cif ();
	mli_limit_cmp u_cmp (.cif(cif));

	// Bus pins come from another domain: two flops before any use
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
		end else begin
			{scl_s1, scl_s2, scl_s3} <= {scl, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
		end
	end

	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
	assign mode = adv_r[ADV_MODE_LO +: 2];
	assign soft_init = wr_stb_r && (ptr_r == OFS_CFG) && wr_dat_r[CFG_INIT];
	assign st_rd = rd_load_r && (ptr_r == OFS_STATUS);
	assign os_wr = wr_stb_r && (ptr_r == OFS_ONESHOT);
	assign run_ok = cfg_r[CFG_START] && !cfg_r[CFG_INT_CLR];
	assign cur_temp = chan_temp(mode, ch_r);
	assign conv_fin = (seq_st == S_CONV) && conv_done;
	assign temp_done = conv_fin && cur_temp;
	assign busy = (seq_st == S_PICK) || (seq_st == S_CONV);

	// Register read view; one-shot and unmapped offsets read zero
	always_comb begin
		rd_val = 8'h00;
		case (ptr_r)
			OFS_CFG: rd_val = cfg_r;
			OFS_STATUS: rd_val = status_r;
			OFS_MASK: rd_val = mask_r;
			OFS_RATE: rd_val = rate_r;
			OFS_DIS: rd_val = dis_r;
			OFS_DEEP: rd_val = deep_r;
			OFS_ADV: rd_val = adv_r;
			OFS_BUSY: rd_val = {6'h00, nrdy_r, busy};
			default: begin
				if (ptr_r >= OFS_READ0 && ptr_r <= OFS_READ7) begin
					rd_val = hi_sel_r ? rd_r[ptr_r[2:0]][15:8] : rd_r[ptr_r[2:0]][7:0];
				end else if (ptr_r >= OFS_LIM0 && ptr_r <= OFS_THYST) begin
					rd_val = lim_r[4'(ptr_r - OFS_LIM0)];
				end
			end
		endcase
	end

	// Serial target: address, pointer, then data bytes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			i_st <= I_IDLE;
			byte_no_r <= 2'h0;
			bit_cnt_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			hi_sel_r <= 1'b1;
			sda_oe_r <= 1'b0;
			wr_stb_r <= 1'b0;
			wr_dat_r <= 8'h00;
			rd_load_r <= 1'b0;
		end else begin
			wr_stb_r <= 1'b0;
			rd_load_r <= 1'b0;
			if (bus_start) begin
				i_st <= I_RX;
				byte_no_r <= 2'h0;
				bit_cnt_r <= 4'h0;
				hi_sel_r <= 1'b1;
				sda_oe_r <= 1'b0;
			end else if (bus_stop) begin
				i_st <= I_IDLE;
				sda_oe_r <= 1'b0;
			end else begin
				case (i_st)
					I_RX: begin
						if (scl_rise) begin
							sh_r <= {sh_r[6:0], sda_s2};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end else if (scl_fall && bit_cnt_r == 4'h8) begin
							if (byte_no_r == 2'h0 && sh_r[7:1] != DEV_ADDR) begin
								i_st <= I_IDLE;
							end else begin
								sda_oe_r <= 1'b1;
								i_st <= I_RX_ACK;
							end
							if (byte_no_r == 2'h0) begin
								rw_r <= sh_r[0];
							end else if (byte_no_r == 2'h1) begin
								ptr_r <= sh_r;
								hi_sel_r <= 1'b1;
							end else begin
								wr_stb_r <= 1'b1;
								wr_dat_r <= sh_r;
							end
						end
					end
					I_RX_ACK: begin
						if (scl_fall) begin
							bit_cnt_r <= 4'h0;
							if (byte_no_r != 2'h2) begin
								byte_no_r <= byte_no_r + 2'h1;
							end
							if (byte_no_r == 2'h0 && rw_r) begin
								tx_r <= rd_val;
								sda_oe_r <= ~rd_val[7];
								rd_load_r <= 1'b1;
								hi_sel_r <= ~hi_sel_r;
								i_st <= I_TX;
							end else begin
								sda_oe_r <= 1'b0;
								i_st <= I_RX;
							end
						end
					end
					I_TX: begin
						if (scl_fall) begin
							if (bit_cnt_r == 4'h7) begin
								sda_oe_r <= 1'b0;
								i_st <= I_TX_ACK;
							end else begin
								tx_r <= {tx_r[6:0], 1'b0};
								sda_oe_r <= ~tx_r[6];
								bit_cnt_r <= bit_cnt_r + 4'h1;
							end
						end
					end
					I_TX_ACK: begin
						if (scl_rise && sda_s2) begin
							i_st <= I_IDLE;
						end else if (scl_fall) begin
							tx_r <= rd_val;
							sda_oe_r <= ~rd_val[7];
							rd_load_r <= 1'b1;
							hi_sel_r <= ~hi_sel_r;
							bit_cnt_r <= 4'h0;
							i_st <= I_TX;
						end
					end
					default: i_st <= I_IDLE;
				endcase
			end
		end
	end

	// Control registers; soft init leaves readings and limits alone
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_r <= RST_CFG;
			mask_r <= RST_MASK;
			rate_r <= RST_RATE;
			dis_r <= RST_DIS;
			deep_r <= RST_DEEP;
			adv_r <= RST_ADV;
		end else if (soft_init) begin
			cfg_r <= RST_CFG;
			mask_r <= RST_MASK;
			rate_r <= RST_RATE;
			dis_r <= RST_DIS;
			deep_r <= RST_DEEP;
			adv_r <= RST_ADV;
		end else if (wr_stb_r) begin
			case (ptr_r)
				OFS_CFG: cfg_r <= wr_dat_r;
				OFS_MASK: mask_r <= wr_dat_r;
				OFS_RATE: rate_r <= wr_dat_r;
				OFS_DIS: dis_r <= wr_dat_r;
				OFS_DEEP: deep_r <= wr_dat_r;
				OFS_ADV: adv_r <= wr_dat_r;
				default: ;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_lim
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					lim_r[g] <= RST_LIM;
				end else if (wr_stb_r && ptr_r == 8'(OFS_LIM0 + g)) begin
					lim_r[g] <= wr_dat_r;
				end
			end
		end
		for (g = 0; g < 8; g++) begin : g_read
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					rd_r[g] <= RST_READ;
				end else if (conv_fin && ch_r == 3'(g)) begin
					rd_r[g] <= conv_data;
				end
			end
		end
	endgenerate

	// Each channel owns a limit pair at its even/odd slot
	assign cif.reading = conv_data;
	assign cif.hi_lim = lim_r[{ch_r, 1'b0}];
	assign cif.lo_lim = lim_r[{ch_r, 1'b1}];
	assign cif.is_temp = cur_temp;

	always_comb begin
		set_vec = 8'h00;
		if (conv_fin) begin
			if (cur_temp) begin
				// Stays raised while hot until cooled and acknowledged
				set_vec[ch_r] = cif.out_lim ||
					(temp_hot_r && !(cif.at_hyst && hyst_rd_r));
			end else begin
				set_vec[ch_r] = cif.out_lim;
			end
		end
	end

	// New events win over a read in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			status_r <= RST_STATUS;
		end else if (soft_init) begin
			status_r <= RST_STATUS;
		end else begin
			status_r <= (status_r & ~{8{st_rd}}) | set_vec;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			temp_hot_r <= 1'b0;
			hyst_rd_r <= 1'b0;
		end else begin
			hyst_rd_r <= st_rd | (hyst_rd_r & ~temp_done);
			if (temp_done && cif.out_lim) begin
				temp_hot_r <= 1'b1;
			end else if (temp_done && cif.at_hyst && hyst_rd_r) begin
				temp_hot_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			int_n_r <= 1'b1;
		end else begin
			int_n_r <= ~(~cfg_r[CFG_INT_CLR] & cfg_r[CFG_INT_EN] &
				(|(status_r & ~mask_r)));
		end
	end

	// Not-ready covers the power-up settling time
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			nrdy_r <= RST_BUSY[BUSY_NRDY];
			rdy_cnt_r <= 32'h0;
		end else if (nrdy_r) begin
			rdy_cnt_r <= rdy_cnt_r + 32'h1;
			nrdy_r <= rdy_cnt_r < 32'(READY_CYCLES - 1);
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			os_pend_r <= 1'b0;
		end else begin
			os_pend_r <= os_wr | (os_pend_r & ~(seq_st == S_OFF || seq_st == S_WAIT));
		end
	end

	always_comb begin
		if (os_act_r || !run_ok) begin
			pass_end_st = S_OFF;
		end else if (rate_r[RATE_CONT]) begin
			pass_end_st = S_PICK;
		end else begin
			pass_end_st = S_WAIT;
		end
	end

	// Round-robin sequencer; channel 7 closes a pass and wraps to 0
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			seq_st <= S_OFF;
			ch_r <= 3'h0;
			tmr_r <= 32'h0;
			os_act_r <= 1'b0;
			conv_start_r <= 1'b0;
			conv_chan_r <= 3'h0;
			conv_temp_r <= 1'b0;
			shut_r <= 1'b1;
		end else begin
			conv_start_r <= 1'b0;
			tmr_r <= tmr_r + 32'h1;
			shut_r <= (seq_st == S_OFF) || (seq_st == S_WAIT);
			case (seq_st)
				S_OFF: begin
					if (run_ok || os_pend_r) begin
						seq_st <= S_PICK;
						ch_r <= 3'h0;
						tmr_r <= 32'h0;
						os_act_r <= ~run_ok;
					end
				end
				S_PICK: begin
					if (cfg_r[CFG_INT_CLR]) begin
						seq_st <= S_OFF;
					end else if (chan_used(mode, ch_r) && !dis_r[ch_r]) begin
						conv_start_r <= 1'b1;
						conv_chan_r <= ch_r;
						conv_temp_r <= cur_temp;
						seq_st <= S_CONV;
					end else begin
						ch_r <= ch_r + 3'h1;
						if (ch_r == TEMP_CH) begin
							seq_st <= pass_end_st;
						end
					end
				end
				S_CONV: begin
					if (conv_done) begin
						ch_r <= ch_r + 3'h1;
						seq_st <= (ch_r == TEMP_CH) ? pass_end_st : S_PICK;
					end
				end
				S_WAIT: begin
					if (!run_ok && !os_pend_r) begin
						seq_st <= S_OFF;
					end else if (os_pend_r || tmr_r >= 32'(LP_PASS_CYCLES - 1)) begin
						seq_st <= S_PICK;
						ch_r <= 3'h0;
						tmr_r <= 32'h0;
						os_act_r <= ~run_ok;
					end
				end
				default: seq_st <= S_OFF;
			endcase
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe = sda_oe_r;
	assign int_n = int_n_r;
	assign conv_start = conv_start_r;
	assign conv_chan = conv_chan_r;
	assign conv_temp = conv_temp_r;
	assign conv_ref_ext = adv_r[ADV_REF];
	assign deep_sleep = deep_r[DEEP_EN];
	assign shutdown = shut_r;

	chk_int_gate: assert property (@(posedge core_clk) disable iff (!rstn)
		!int_n |-> $past(!cfg_r[CFG_INT_CLR] && cfg_r[CFG_INT_EN] && (|(status_r & ~mask_r))))
		else $error("alert low without its three conditions");
	chk_clear_releases: assert property (@(posedge core_clk) disable iff (!rstn)
		cfg_r[CFG_INT_CLR] |=> int_n)
		else $error("alert held while clear bit set");
	chk_halt_loop: assert property (@(posedge core_clk) disable iff (!rstn)
		cfg_r[CFG_INT_CLR] && seq_st == S_PICK |=> seq_st == S_OFF && !conv_start)
		else $error("loop not halted by clear bit");
	chk_read_clears: assert property (@(posedge core_clk) disable iff (!rstn)
		st_rd && set_vec == 8'h00 |=> status_r == 8'h00 ##1 int_n)
		else $error("status read did not clear status and alert");
	chk_mask_blocks: assert property (@(posedge core_clk) disable iff (!rstn)
		(status_r & ~mask_r) == 8'h00 |=> int_n)
		else $error("masked status reached alert");
	chk_sticky_bits: assert property (@(posedge core_clk) disable iff (!rstn)
		!st_rd && !soft_init |=> (status_r & $past(status_r)) == $past(status_r))
		else $error("status bit lost without read");
	chk_temp_event: assert property (@(posedge core_clk) disable iff (!rstn)
		temp_done && cif.out_lim |=> status_r[TEMP_CH] && temp_hot_r)
		else $error("hot reading did not flag");
	chk_temp_repeat: assert property (@(posedge core_clk) disable iff (!rstn)
		temp_done && temp_hot_r && !(cif.at_hyst && hyst_rd_r) |=> status_r[TEMP_CH])
		else $error("temperature event not raised again");
	chk_volt_low: assert property (@(posedge core_clk) disable iff (!rstn)
		conv_fin && !cur_temp && conv_data[11:4] <= cif.lo_lim |=> status_r[$past(ch_r)])
		else $error("voltage at low limit not flagged");
	chk_temp_scale: assert property (@(posedge core_clk) disable iff (!rstn)
		cur_temp && conv_data[8:0] == 9'h001 && cif.hi_lim == 8'h00 |-> cif.out_lim)
		else $error("half degree not above zero limit");
	chk_neg_limit: assert property (@(posedge core_clk) disable iff (!rstn)
		cur_temp && conv_data[8:0] == 9'h1FE && cif.hi_lim == 8'hFF |-> !cif.out_lim)
		else $error("minus one degree misread against limit");
	chk_skip_disabled: assert property (@(posedge core_clk) disable iff (!rstn)
		conv_start |-> !dis_r[conv_chan])
		else $error("disabled channel converted");
	chk_mode_chans: assert property (@(posedge core_clk) disable iff (!rstn)
		conv_start |-> chan_used(mode, conv_chan) && conv_temp == chan_temp(mode, conv_chan))
		else $error("channel outside current mode");
	chk_oneshot_go: assert property (@(posedge core_clk) disable iff (!rstn)
		os_wr && seq_st == S_OFF && !run_ok && !os_pend_r |-> ##2 seq_st == S_PICK)
		else $error("one-shot write did not start a pass");
	chk_stay_off: assert property (@(posedge core_clk) disable iff (!rstn)
		seq_st == S_OFF && !cfg_r[CFG_START] && !os_pend_r |=> seq_st == S_OFF)
		else $error("loop ran with start low");

	cov_temp_event: cover property (@(posedge core_clk) disable iff (!rstn)
		temp_done && cif.out_lim ##[1:50] !int_n);
	cov_status_read: cover property (@(posedge core_clk) disable iff (!rstn)
		st_rd && status_r != 8'h00);
	cov_low_power: cover property (@(posedge core_clk) disable iff (!rstn)
		seq_st == S_WAIT ##1 seq_st == S_PICK);
	cov_oneshot: cover property (@(posedge core_clk) disable iff (!rstn)
		os_wr ##[1:4] conv_start);
endmodule : mli_top

// ### test/mli_host_model.sv
`timescale 1ns/1ps
module mli_host_model #(
	parameter logic [6:0] ADDR = 7'h1D
) (
	input wire logic core_clk,
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	int nak_cnt = 0;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	// Data moves a cycle after scl falls, so no false start or stop is seen
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_low = ~b;
		tick(3);
		scl = 1'b1;
		tick(4);
		r = sda;
		scl = 1'b0;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q,
		output logic ak_seen);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ak, ak_seen);
	endtask : byte_io
	task automatic put(input logic [7:0] d);
		logic [7:0] q;
		logic a;
		byte_io(d, 1'b1, q, a);
		if (a !== 1'b0)
			nak_cnt++;
	endtask : put
	// Waits out the device ack before raising scl for a repeated start
	task automatic start();
		tick(1);
		sda_low = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		tick(1);
		sda_low = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b0;
		tick(4);
	endtask : stop
	task automatic reg_write(input logic [7:0] o, input logic [7:0] d);
		start();
		put({ADDR, 1'b0});
		put(o);
		put(d);
		stop();
	endtask : reg_write
	// One byte only for 8-bit places: a second status byte would see it cleared
	task automatic reg_read(input logic [7:0] o, input bit two, output logic [15:0] v);
		logic a;
		v = 16'h0000;
		start();
		put({ADDR, 1'b0});
		put(o);
		start();
		put({ADDR, 1'b1});
		byte_io(8'hFF, ~two, v[15:8], a);
		if (two)
			byte_io(8'hFF, 1'b1, v[7:0], a);
		else
			v = {8'h00, v[15:8]};
		stop();
	endtask : reg_read
endmodule : mli_host_model

// ### test/mli_top_bench.sv
`timescale 1ns/1ps
module mli_top_bench;
	import mli_pkg::*;
	localparam int LP = 3000;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic conv_done = 1'b0;
	logic [15:0] conv_data = 16'h0000;
	logic scl, host_low, sda_oe, int_n, conv_start, conv_temp, conv_ref_ext, deep_sleep, shutdown;
	logic [2:0] conv_chan, cch;
	logic [15:0] vals [8];
	logic [1:0] md = 2'h0;
	int n_fail = 0;
	int total_checks = 0;
	int n_conv = 0;
	int cyc = 0;
	wire logic sda_w = ~(host_low | sda_oe);

	always #5 core_clk = ~core_clk;

	mli_top #(.LP_PASS_CYCLES(LP), .READY_CYCLES(2000)) u_mli_top (
		.core_clk(core_clk), .rstn(rstn), .scl(scl), .sda_i(sda_w), .sda_o(),
		.sda_oe(sda_oe), .int_n(int_n), .conv_start(conv_start), .conv_chan(conv_chan),
		.conv_temp(conv_temp), .conv_ref_ext(conv_ref_ext), .deep_sleep(deep_sleep),
		.shutdown(shutdown), .conv_done(conv_done), .conv_data(conv_data));
	mli_host_model u_mli_host_model (.core_clk(core_clk), .scl(scl), .sda_low(host_low),
		.sda(sda_w));

	// Converter stand-in; data inverted outside the strobe so stale values never match
	always @(posedge core_clk) begin
		if (conv_start === 1'b1) begin
			n_conv++;
			cch = conv_chan;
			pin("conv_temp", cch == 3'h7 && md != 2'h1, conv_temp);
			repeat (3) @(posedge core_clk);
			#1;
			conv_data = vals[cch];
			conv_done = 1'b1;
			@(posedge core_clk);
			#1;
			conv_done = 1'b0;
			conv_data = ~vals[cch];
		end
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic test_done();
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		u_mli_host_model.reg_write(o, d);
	endtask : wr
	task automatic rc(input string nm, input logic [7:0] o, input bit two, input logic [15:0] e);
		logic [15:0] v;
		u_mli_host_model.reg_read(o, two, v);
		chk(nm, e, v);
	endtask : rc
	task automatic pin(input string nm, input logic e, input logic g);
		chk(nm, {15'h0000, e}, {15'h0000, g});
	endtask : pin
	// Bounded wait until the converter has seen a total number of requests
	task automatic wait_conv(input int target);
		for (int i = 0; i < LP + 500 && n_conv < target; i++)
			@(posedge core_clk);
		repeat (12) @(posedge core_clk);
		#1;
		chk("conv_count", target[15:0], n_conv[15:0]);
	endtask : wait_conv

	initial begin
		static logic [7:0] rs_ofs [10] = '{OFS_BUSY, OFS_CFG, OFS_STATUS, OFS_MASK, OFS_RATE,
			OFS_DIS, OFS_DEEP, OFS_ADV, OFS_ONESHOT, 8'h02};
		static logic [7:0] rs_val [10] = '{RST_BUSY, RST_CFG, RST_STATUS, RST_MASK, RST_RATE,
			RST_DIS, RST_DEEP, RST_ADV, 8'h00, 8'h00};
		static logic [7:0] lim_ofs [11] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31,
			OFS_THOT, OFS_THYST, OFS_DIS};
		static logic [7:0] lim_val [11] = '{8'h80, 8'h20, 8'h81, 8'h20, 8'hFF, 8'h20, 8'hFF, 8'h20,
			8'h19, 8'h18, 8'h70};
		static int ncnt [4] = '{8, 8, 5, 7};
		int nc;
		vals = '{16'h0810, 16'h0810, 16'h0200, 16'h0210, 16'h0000, 16'h0000, 16'h0000, 16'h0034};
		repeat (20) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		u_mli_host_model.tick(3);
		for (int i = 0; i < 10; i++)
			rc("reset_value", rs_ofs[i], 0, {8'h00, rs_val[i]});
		rc("busy", OFS_BUSY, 0, 16'h0000);
		for (int i = 0; i < 11; i++)
			wr(lim_ofs[i], lim_val[i]);
		rc("hot_limit", OFS_THOT, 0, 16'h0019);
		nc = n_conv;
		wr(OFS_CFG, 8'h03);
		wait_conv(nc + 5);
		pin("int_n", 1'b0, int_n);
		pin("shutdown", 1'b1, shutdown);
		rc("status", OFS_STATUS, 0, 16'h0085);
		pin("int_n", 1'b1, int_n);
		rc("reading0", OFS_READ0, 1, 16'h0810);
		rc("reading4", 8'h24, 1, 16'h0000);
		rc("reading7", OFS_READ7, 1, 16'h0034);
		wait_conv(nc + 10);
		pin("int_n", 1'b0, int_n);
		wr(OFS_MASK, 8'h85);
		pin("int_n", 1'b1, int_n);
		rc("status", OFS_STATUS, 0, 16'h0085);
		wr(OFS_MASK, 8'h00);
		wait_conv(nc + 15);
		wr(OFS_CFG, 8'h0B);
		pin("int_n", 1'b1, int_n);
		nc = n_conv;
		repeat (LP + 200) @(posedge core_clk);
		#1;
		chk("halted", nc[15:0], n_conv[15:0]);
		rc("status", OFS_STATUS, 0, 16'h0085);
		wr(OFS_DIS, 8'h7F);
		nc = n_conv;
		wr(OFS_CFG, 8'h03);
		wait_conv(nc + 1);
		rc("status", OFS_STATUS, 0, 16'h0080);
		vals[7] = 16'h0032;
		wait_conv(nc + 2);
		rc("status", OFS_STATUS, 0, 16'h0080);
		vals[7] = 16'h0030;
		wait_conv(nc + 3);
		rc("status", OFS_STATUS, 0, 16'h0000);
		wr(OFS_CFG, 8'h02);
		wr(OFS_DIS, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_ADV, {5'h00, m[1:0], 1'b1});
			md = m[1:0];
			nc = n_conv;
			wr(OFS_ONESHOT, 8'hA5);
			wait_conv(nc + ncnt[m]);
			pin("ref_ext", 1'b1, conv_ref_ext);
			pin("shutdown", 1'b1, shutdown);
		end
		wr(OFS_DEEP, 8'h01);
		pin("deep_sleep", 1'b1, deep_sleep);
		wr(OFS_RATE, 8'h01);
		rc("rate", OFS_RATE, 0, 16'h0001);
		wr(OFS_READ0, 8'hFF);
		rc("reading0", OFS_READ0, 1, 16'h0810);
		wr(OFS_CFG, 8'h80);
		rc("soft_init", OFS_CFG, 0, 16'h0008);
		rc("rate_init", OFS_RATE, 0, 16'h0000);
		chk("nak", 16'h0000, u_mli_host_model.nak_cnt[15:0]);
		test_done();
	end
endmodule : mli_top_bench
